/* core/gpio_ctrl_pkg.sv */
package gpio_ctrl_pkg;

   // ***********************************************************
   // clock and sizing
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int NUM_PINS      = 2;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 16;

   // ***********************************************************
   // register map (index 0 is pin 3, index 1 is pin 4)
   // ***********************************************************
   localparam logic [ADDR_W-1:0] PIN_CONTROL_ADDR [NUM_PINS] = '{8'h76, 8'h77};
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR  = 8'h7c;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR    = 8'h7d;
   localparam logic [ADDR_W-1:0] PIN_STATE_ADDR   = 8'h7e;

   localparam logic [DATA_W-1:0] PIN_CONTROL_RESET [NUM_PINS] = '{16'h00a8, 16'h0220};
   localparam logic [DATA_W-1:0] CTRL_WRITE_MASK  = 16'h3fff;

   // ***********************************************************
   // control word fields
   // ***********************************************************
   localparam int FUNC_MSB  = 13;
   localparam int FUNC_LSB  = 8;
   localparam int DIR_BIT   = 7;
   localparam int DRIVE_BIT = 6;
   localparam int POL_BIT   = 5;
   localparam int LVL_BIT   = 4;
   localparam int PD_BIT    = 3;
   localparam int PU_BIT    = 2;
   localparam int TRIG_BIT  = 1;
   localparam int DB_BIT    = 0;

   typedef enum logic [5:0] {
      FN_GPIO_OUT   = 6'h00,
      FN_IRQ_OUT    = 6'h02,
      FN_GPIO_IN    = 6'h03,
      FN_MIC_DETECT = 6'h04,
      FN_MIC_SHORT  = 6'h05,
      FN_LOCK_OUT   = 6'h08,
      FN_LOOP_CLK   = 6'h09
   } func_code_t;

   // ***********************************************************
   // debounce timing
   // ***********************************************************
   localparam int DEBOUNCE_TIME_NS     = 1000000;
   localparam int DEBOUNCE_CYCLES_DFLT = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // true for codes that put a value on the pin
   function automatic logic func_drives(input logic [5:0] code);
      logic res;
      res = 1'b0;
      case (code)
         FN_GPIO_OUT, FN_IRQ_OUT, FN_MIC_DETECT, FN_MIC_SHORT, FN_LOCK_OUT, FN_LOOP_CLK:
            res = 1'b1;
         default:
            res = 1'b0;
      endcase
      return res;
   endfunction

endpackage

/* core/gpio_pin3_pin4_control.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module gpio_pin3_pin4_control
   import gpio_ctrl_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DFLT
)(
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [DATA_W-1:0]      rdata_o,
   input  wire logic [1:0]        pin_in_i,
   output logic [1:0]             pin_out_o,
   output logic [1:0]             pin_oe_o,
   output logic [1:0]             pullup_en_o,
   output logic [1:0]             pulldown_en_o,
   input  wire logic              mic_detect_i,
   input  wire logic              mic_short_i,
   input  wire logic              loop_lock_i,
   input  wire logic              loop_clk_i,
   output logic                   irq_o
);

   if (DEBOUNCE_CYCLES < 1)
   begin : g_bad
      $error("gpio_pin3_pin4_control: DEBOUNCE_CYCLES must be at least 1");
   end

   // ***********************************************************
   // state
   // ***********************************************************
   logic [DATA_W-1:0]   ctrl_q [NUM_PINS];
   logic [DATA_W-1:0]   ctrl_d [NUM_PINS];
   logic [NUM_PINS-1:0] status_q;
   logic [NUM_PINS-1:0] status_d;
   logic [NUM_PINS-1:0] mask_q;
   logic [NUM_PINS-1:0] mask_d;
   logic [NUM_PINS-1:0] act_q;
   logic [DATA_W-1:0]   rdata_q;
   logic [DATA_W-1:0]   rdata_d;
   logic                irq_q;
   logic                irq_d;
   logic [NUM_PINS-1:0] deb;
   logic [NUM_PINS-1:0] act;
   logic [NUM_PINS-1:0] event_hit;
   logic [5:0]          func [NUM_PINS];

   // ***********************************************************
   // per pin input path and pin driver
   // ***********************************************************
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      assign func[i] = ctrl_q[i][FUNC_MSB:FUNC_LSB];

      // debounce only when bit 0 is set
      pin_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .enable_i (ctrl_q[i][DB_BIT]),
         .raw_i    (pin_in_i[i]),
         .level_o  (deb[i])
      );

      // polarity and trigger style of the pin event
      assign act[i] = ctrl_q[i][POL_BIT] ? deb[i] : !deb[i];
      assign event_hit[i] = (func[i] == FN_GPIO_IN)
                          && (ctrl_q[i][TRIG_BIT] ? (act[i] && !act_q[i]) : act[i]);

      // routes level, irq, detects and loop signals; reserved idle
      pin_driver u_drv (
         .clk_i        (clk_i),
         .resetn_i     (resetn_i),
         .func_i       (func[i]),
         .dir_in_i     (ctrl_q[i][DIR_BIT]),
         .open_drain_i (ctrl_q[i][DRIVE_BIT]),
         .level_i      (ctrl_q[i][LVL_BIT]),
         .irq_i        (irq_q),
         .mic_detect_i (mic_detect_i),
         .mic_short_i  (mic_short_i),
         .loop_lock_i  (loop_lock_i),
         .loop_clk_i   (loop_clk_i),
         .pin_out_o    (pin_out_o[i]),
         .pin_oe_o     (pin_oe_o[i])
      );

      // pull resistor enables straight from the control flops
      assign pulldown_en_o[i] = ctrl_q[i][PD_BIT];
      assign pullup_en_o[i]   = ctrl_q[i][PU_BIT];
   end

   // ***********************************************************
   // register writes, sticky status, interrupt, read data
   // ***********************************************************
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         ctrl_d[i] = ctrl_q[i];
         if (wr_i && addr_i == PIN_CONTROL_ADDR[i])
         begin
            ctrl_d[i] = wdata_i & CTRL_WRITE_MASK;
         end
      end
      mask_d = mask_q;
      if (wr_i && addr_i == IRQ_MASK_ADDR)
      begin
         mask_d = wdata_i[NUM_PINS-1:0];
      end
      // write one clears; a new event wins over the clear
      status_d = status_q;
      if (wr_i && addr_i == IRQ_STATUS_ADDR)
      begin
         status_d = status_q & ~wdata_i[NUM_PINS-1:0];
      end
      status_d = status_d | event_hit;
      irq_d    = |(status_d & mask_d);
      rdata_d  = '0;
      if (rd_i)
      begin
         if (addr_i == PIN_CONTROL_ADDR[0])
         begin
            rdata_d = ctrl_q[0];
         end
         else if (addr_i == PIN_CONTROL_ADDR[1])
         begin
            rdata_d = ctrl_q[1];
         end
         else if (addr_i == IRQ_STATUS_ADDR)
         begin
            rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, status_q};
         end
         else if (addr_i == IRQ_MASK_ADDR)
         begin
            rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, mask_q};
         end
         else if (addr_i == PIN_STATE_ADDR)
         begin
            rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, act};
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q[0] <= PIN_CONTROL_RESET[0];
         ctrl_q[1] <= PIN_CONTROL_RESET[1];
         status_q  <= '0;
         mask_q    <= '0;
         act_q     <= '0;
         rdata_q   <= '0;
         irq_q     <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         status_q  <= status_d;
         mask_q    <= mask_d;
         act_q     <= act;
         rdata_q   <= rdata_d;
         irq_q     <= irq_d;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o   = irq_q;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   logic seen_q;

   // low only in the first cycle after reset
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         seen_q <= 1'b0;
      end
      else
      begin
         seen_q <= 1'b1;
      end
   end

   chk_reset_words: assert property (
      !seen_q |-> ctrl_q[0] == PIN_CONTROL_RESET[0] && ctrl_q[1] == PIN_CONTROL_RESET[1])
      else $error("control words wrong after reset");

   chk_out_level: assert property (
      (func[0] == FN_GPIO_OUT && !ctrl_q[0][DIR_BIT] && !ctrl_q[0][DRIVE_BIT])
      |=> pin_oe_o[0] && pin_out_o[0] == $past(ctrl_q[0][LVL_BIT]))
      else $error("pin 3 output level not driven");

   chk_input_idle: assert property (
      func[1] == FN_GPIO_IN |=> !pin_oe_o[1])
      else $error("input pin is driven");

   chk_irq_pin: assert property (
      (func[1] == FN_IRQ_OUT && !ctrl_q[1][DIR_BIT] && !ctrl_q[1][DRIVE_BIT])
      |=> pin_oe_o[1] && pin_out_o[1] == $past(irq_q))
      else $error("pin 4 does not carry interrupt");

   chk_mic_route: assert property (
      (func[0] == FN_MIC_SHORT && !ctrl_q[0][DIR_BIT] && !ctrl_q[0][DRIVE_BIT])
      |=> pin_out_o[0] == $past(mic_short_i))
      else $error("short detect not routed");

   chk_lock_route: assert property (
      (func[1] == FN_LOCK_OUT && !ctrl_q[1][DIR_BIT] && !ctrl_q[1][DRIVE_BIT])
      |=> pin_out_o[1] == $past(loop_lock_i))
      else $error("lock status not routed");

   chk_reserved_idle: assert property (
      !func_drives(func[0]) |=> !pin_oe_o[0] && !pin_out_o[0])
      else $error("reserved function drives pin");

   chk_open_drain: assert property (
      ctrl_q[1][DRIVE_BIT] |=> !pin_out_o[1])
      else $error("open drain drove high");

   chk_pull_write: assert property (
      (wr_i && addr_i == PIN_CONTROL_ADDR[0])
      |=> pulldown_en_o[0] == $past(wdata_i[PD_BIT]) && pullup_en_o[0] == $past(wdata_i[PU_BIT]))
      else $error("pull enables ignore write");

   chk_debounce_off: assert property (
      !ctrl_q[0][DB_BIT] |=> deb[0] == $past(pin_in_i[0]))
      else $error("undebounced input delayed");

   chk_level_event: assert property (
      (func[0] == FN_GPIO_IN && !ctrl_q[0][TRIG_BIT] && act[0]) |=> status_q[0])
      else $error("level event not captured");

   chk_edge_event: assert property (
      (func[0] == FN_GPIO_IN && ctrl_q[0][TRIG_BIT] && act[0] && !$past(act[0]))
      |=> status_q[0])
      else $error("edge event not captured");

   chk_status_clear: assert property (
      (wr_i && addr_i == IRQ_STATUS_ADDR && wdata_i[0] && !event_hit[0]) |=> !status_q[0])
      else $error("status bit not cleared");

   chk_irq_level: assert property (
      irq_o == |(status_q & mask_q))
      else $error("interrupt not level of unmasked status");

   chk_mask_write: assert property (
      (wr_i && addr_i == IRQ_MASK_ADDR) |=> mask_q == $past(wdata_i[NUM_PINS-1:0]))
      else $error("mask ignores write");

   chk_read_data: assert property (
      (rd_i && addr_i == PIN_CONTROL_ADDR[1]) |=> rdata_o == $past(ctrl_q[1]))
      else $error("pin 4 control word read wrong");

   chk_read_idle: assert property (
      !rd_i |=> rdata_o == '0)
      else $error("read data stand too long");

   chk_mic_detect: assert property (
      (func[0] == FN_MIC_DETECT && !ctrl_q[0][DIR_BIT] && !ctrl_q[0][DRIVE_BIT])
      |=> pin_out_o[0] == $past(mic_detect_i))
      else $error("current detect not routed");

   chk_loop_clk: assert property (
      (func[0] == FN_LOOP_CLK && !ctrl_q[0][DIR_BIT] && !ctrl_q[0][DRIVE_BIT])
      |=> pin_out_o[0] == $past(loop_clk_i))
      else $error("loop clock not routed");

   chk_reserved_pin4: assert property (
      !func_drives(func[1]) |=> !pin_oe_o[1] && !pin_out_o[1])
      else $error("reserved function drives pin 4");

   chk_direction_in: assert property (
      ctrl_q[0][DIR_BIT] |=> !pin_oe_o[0])
      else $error("input direction still drives pin");

   chk_pull_pin4: assert property (
      (wr_i && addr_i == PIN_CONTROL_ADDR[1])
      |=> pulldown_en_o[1] == $past(wdata_i[PD_BIT]) && pullup_en_o[1] == $past(wdata_i[PU_BIT]))
      else $error("pin 4 pull enables ignore write");

   // scenarios the tests should reach
   cov_irq_pin: cover property (func[1] == FN_IRQ_OUT ##1 pin_out_o[1]);
   cov_edge_event: cover property (ctrl_q[0][TRIG_BIT] && event_hit[0]);
   cov_loop_clk: cover property (func[0] == FN_LOOP_CLK && pin_out_o[0] ##1 !pin_out_o[0]);
   cov_set_beats_clear: cover property (wr_i && addr_i == IRQ_STATUS_ADDR && |event_hit);
   cov_pin4_input: cover property (func[1] == FN_GPIO_IN && event_hit[1]);

endmodule

/* core/pin_debounce.sv */
`timescale 1ns/1ps
module pin_debounce
   import gpio_ctrl_pkg::*;
#(
   parameter int CYCLES = DEBOUNCE_CYCLES_DFLT
)(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic enable_i,
   input  wire logic raw_i,
   output logic      level_o
);
   localparam int CNT_W = $clog2(CYCLES + 1);

   if (CYCLES < 1)
   begin : g_bad
      $error("pin_debounce: CYCLES must be at least 1");
   end

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             level_q;
   logic             level_d;

   // bypass when disabled, else accept a level only once stable
   always_comb
   begin
      cnt_d   = '0;
      level_d = level_q;
      if (!enable_i)
      begin
         level_d = raw_i;
      end
      else if (raw_i != level_q)
      begin
         if (cnt_q == CNT_W'(CYCLES - 1))
         begin
            level_d = raw_i;
         end
         else
         begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_q   <= '0;
         level_q <= 1'b0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;
endmodule

/* core/pin_driver.sv */
`timescale 1ns/1ps
module pin_driver
   import gpio_ctrl_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [5:0] func_i,
   input  wire logic       dir_in_i,
   input  wire logic       open_drain_i,
   input  wire logic       level_i,
   input  wire logic       irq_i,
   input  wire logic       mic_detect_i,
   input  wire logic       mic_short_i,
   input  wire logic       loop_lock_i,
   input  wire logic       loop_clk_i,
   output logic            pin_out_o,
   output logic            pin_oe_o
);
   logic out_q;
   logic out_d;
   logic oe_q;
   logic oe_d;
   logic value;
   logic enable;

   // pick the source for the selected function
   always_comb
   begin
      case (func_i)
         FN_GPIO_OUT:   value = level_i;
         FN_IRQ_OUT:    value = irq_i;
         FN_MIC_DETECT: value = mic_detect_i;
         FN_MIC_SHORT:  value = mic_short_i;
         FN_LOCK_OUT:   value = loop_lock_i;
         FN_LOOP_CLK:   value = loop_clk_i;
         default:       value = 1'b0;
      endcase
      enable = func_drives(func_i) && !dir_in_i;
      // open drain only ever pulls low
      out_d  = enable && !open_drain_i && value;
      oe_d   = enable && (!open_drain_i || !value);
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         out_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         oe_q  <= oe_d;
      end
   end

   assign pin_out_o = out_q;
   assign pin_oe_o  = oe_q;
endmodule

/* verification/gpio_board_model.sv */
`timescale 1ns/1ps
module gpio_board_model
(
   input  wire logic       clk_i,
   input  wire logic [1:0] pin_out_i,
   input  wire logic [1:0] pin_oe_i,
   input  wire logic [1:0] pullup_en_i,
   input  wire logic [1:0] pulldown_en_i,
   input  wire logic [1:0] ext_en_i,
   input  wire logic [1:0] ext_val_i,
   output logic [1:0]      pin_level_o
);
   logic [1:0] float_q = 2'b01;

   // an undriven, unpulled wire wanders every cycle
   always_ff @(posedge clk_i)
   begin
      float_q <= ~float_q;
   end

   // wire level from device drive, board drive and pulls
   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         if (pin_oe_i[k])
            pin_level_o[k] = pin_out_i[k];
         else if (ext_en_i[k])
            pin_level_o[k] = ext_val_i[k];
         else if (pullup_en_i[k])
            pin_level_o[k] = 1'b1;
         else if (pulldown_en_i[k])
            pin_level_o[k] = 1'b0;
         else
            pin_level_o[k] = float_q[k];
      end
   end
endmodule

/* verification/test_gpio_pin3_pin4_control.sv */
`timescale 1ns/1ps
module test_gpio_pin3_pin4_control
   import gpio_ctrl_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic        irq;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [1:0]  pin_lvl;
   logic [1:0]  pin_out;
   logic [1:0]  pin_oe;
   logic [1:0]  pu;
   logic [1:0]  pd;
   logic [1:0]  ext_en;
   logic [1:0]  ext_val;
   logic [3:0]  src;
   logic [5:0]  fcode [4] = '{6'h04, 6'h05, 6'h08, 6'h09};
   logic [5:0]  rsvd [5]  = '{6'h01, 6'h06, 6'h07, 6'h0a, 6'h3f};
   int          n_mismatch;
   int          num_checks;

   gpio_pin3_pin4_control #(.DEBOUNCE_CYCLES(4)) dut (
      .clk_i(clk), .resetn_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pin_out),
      .pin_oe_o(pin_oe), .pullup_en_o(pu), .pulldown_en_o(pd), .mic_detect_i(src[0]),
      .mic_short_i(src[1]), .loop_lock_i(src[2]), .loop_clk_i(src[3]), .irq_o(irq));

   gpio_board_model board (
      .clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pullup_en_i(pu),
      .pulldown_en_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(pin_lvl));

   // ***********************************************************
   // bus and compare tasks
   // ***********************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ***********************************************************
   // clock, watchdog and tests
   // ***********************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #100us;
      n_mismatch++;
      tally_and_finish();
   end

   initial
   begin
      rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
      ext_en = 2'b00; ext_val = 2'b00; src = 4'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk({12'h000, pd, pu}, 16'h0004);
      chk({14'h0000, pin_oe}, 16'h0002);
      reg_rd(8'h76, 16'h00a8);
      reg_rd(8'h77, 16'h0220);
      reg_rd(8'h80, 16'h0000);
      reg_wr(8'h76, 16'hffff);
      reg_rd(8'h76, 16'h3fff);
      reg_wr(8'h76, 16'h000c);
      settle();
      chk({12'h000, pd, pu}, 16'h0005);
      // level, direction and drive type on the plain output
      reg_wr(8'h76, 16'h0010);
      settle();
      chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0003);
      reg_wr(8'h76, 16'h0000);
      settle();
      chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0002);
      reg_wr(8'h76, 16'h0090);
      settle();
      chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0000);
      reg_wr(8'h76, 16'h0050);
      settle();
      chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0000);
      reg_wr(8'h76, 16'h0040);
      settle();
      chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0002);
      // each source reaches the pin alone, level bit ignored
      for (int i = 0; i < 4; i++)
      begin
         reg_wr(8'h76, {2'b00, fcode[i], 8'h10});
         src <= 4'hf ^ (4'h1 << i);
         settle();
         chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0002);
         src <= 4'h1 << i;
         settle();
         chk({14'h0000, pin_oe[0], pin_out[0]}, 16'h0003);
      end
      for (int i = 0; i < 5; i++)
      begin
         reg_wr(8'h76, {2'b00, rsvd[i], 8'h10});
         settle();
         chk({15'h0000, pin_oe[0]}, 16'h0000);
      end
      // level interrupt, routed to pin 4
      @(posedge clk) ext_en <= 2'b01;
      reg_wr(8'h7d, 16'h0001);
      reg_rd(8'h7d, 16'h0001);
      reg_wr(8'h76, 16'h03a0);
      reg_wr(8'h7c, 16'h0003);
      settle();
      reg_rd(8'h7c, 16'h0000);
      @(posedge clk) ext_val <= 2'b01;
      settle();
      chk({14'h0000, irq, pin_out[1]}, 16'h0003);
      // pin 4 drives the raised interrupt, so it reads active too
      reg_rd(8'h7e, 16'h0003);
      reg_wr(8'h7c, 16'h0001);
      settle();
      reg_rd(8'h7c, 16'h0001);
      reg_wr(8'h7d, 16'h0000);
      settle();
      chk({14'h0000, irq, pin_out[1]}, 16'h0000);
      // edge mode: a held level does not set again
      reg_wr(8'h76, 16'h03a2);
      reg_wr(8'h7c, 16'h0001);
      settle();
      reg_rd(8'h7c, 16'h0000);
      @(posedge clk) ext_val <= 2'b00;
      settle();
      @(posedge clk) ext_val <= 2'b01;
      settle();
      reg_rd(8'h7c, 16'h0001);
      // active low polarity
      reg_wr(8'h76, 16'h0380);
      reg_wr(8'h7c, 16'h0001);
      settle();
      reg_rd(8'h7c, 16'h0000);
      reg_rd(8'h7e, 16'h0000);
      @(posedge clk) ext_val <= 2'b00;
      settle();
      reg_rd(8'h7c, 16'h0001);
      reg_rd(8'h7e, 16'h0001);
      // undebounced input follows quickly, debounced one waits
      reg_wr(8'h76, 16'h03a0);
      settle();
      @(posedge clk) ext_val <= 2'b01;
      repeat (2) @(posedge clk);
      reg_rd(8'h7e, 16'h0001);
      @(posedge clk) ext_val <= 2'b00;
      reg_wr(8'h76, 16'h03a1);
      settle();
      @(posedge clk) ext_val <= 2'b01;
      reg_rd(8'h7e, 16'h0000);
      settle();
      settle();
      reg_rd(8'h7e, 16'h0001);
      // pin 4 as lock output, open drain and floating input
      reg_wr(8'h77, 16'h0800);
      settle();
      chk({14'h0000, pin_oe[1], pin_out[1]}, 16'h0002);
      @(posedge clk) src <= 4'h4;
      settle();
      chk({14'h0000, pin_oe[1], pin_out[1]}, 16'h0003);
      reg_wr(8'h77, 16'h0840);
      settle();
      chk({14'h0000, pin_oe[1], pin_out[1]}, 16'h0000);
      reg_wr(8'h77, 16'h0380);
      settle();
      chk({14'h0000, pin_oe[1], pin_out[1]}, 16'h0000);
      reg_rd(8'h7c, 16'h0003);
      // reset in mid-run restores both control words
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk({14'h0000, pin_oe}, 16'h0002);
      reg_rd(8'h77, 16'h0220);
      reg_rd(8'h7c, 16'h0000);
      tally_and_finish();
   end
endmodule
